// file: common/ifb_pkg.sv
// Shared constants for the interrupt flag and enable bank
package ifb_pkg;

   // ==========================================================
   // Register select codes on the core data port
   localparam logic [2:0] REG_EDGE     = 3'h0;
   localparam logic [2:0] REG_CTRL_A   = 3'h1;
   localparam logic [2:0] REG_CTRL_B   = 3'h2;
   localparam logic [2:0] REG_CTRL_C   = 3'h3;
   localparam logic [2:0] REG_GRP_TMR  = 3'h4;
   localparam logic [2:0] REG_GRP_PWML = 3'h5;
   localparam logic [2:0] REG_GRP_PWMH = 3'h6;
   localparam int         NUM_REGS     = 7;

   // ==========================================================
   // Reset value and implemented bits of each register
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] IMPL_MASK [NUM_REGS] = '{8'h0F, 8'h7F, 8'hFF, 8'h33,
                                                   8'hFF, 8'hFF, 8'h33};

   // ==========================================================
   // Edge field positions and codes
   localparam int         EDGE_PIN0_LSB = 0;
   localparam int         EDGE_PIN1_LSB = 2;
   localparam logic [1:0] EDGE_OFF      = 2'h0;
   localparam logic [1:0] EDGE_RISE     = 2'h1;
   localparam logic [1:0] EDGE_FALL     = 2'h2;
   localparam logic [1:0] EDGE_BOTH     = 2'h3;

   // ==========================================================
   // Bit positions in the primary control registers
   localparam logic [2:0] CA_GIE       = 3'h0;
   localparam logic [2:0] CA_PIN0_EN   = 3'h1;
   localparam logic [2:0] CA_PIN1_EN   = 3'h2;
   localparam logic [2:0] CA_G0_EN     = 3'h3;
   localparam logic [2:0] CA_PIN0_REQ  = 3'h4;
   localparam logic [2:0] CA_PIN1_REQ  = 3'h5;
   localparam logic [2:0] CA_G0_REQ    = 3'h6;
   localparam logic [2:0] CB_T0_EN     = 3'h0;
   localparam logic [2:0] CB_T1_EN     = 3'h1;
   localparam logic [2:0] CB_G1_EN     = 3'h2;
   localparam logic [2:0] CB_G2_EN     = 3'h3;
   localparam logic [2:0] CB_T0_REQ    = 3'h4;
   localparam logic [2:0] CB_T1_REQ    = 3'h5;
   localparam logic [2:0] CB_G1_REQ    = 3'h6;
   localparam logic [2:0] CB_G2_REQ    = 3'h7;
   localparam logic [2:0] CC_AD_EN     = 3'h0;
   localparam logic [2:0] CC_LV_EN     = 3'h1;
   localparam logic [2:0] CC_AD_REQ    = 3'h4;
   localparam logic [2:0] CC_LV_REQ    = 3'h5;

   // ==========================================================
   // Dispatchable sources, lowest index has highest priority
   localparam int         NUM_SRC  = 9;
   localparam int         SRC_W    = 4;
   localparam logic [3:0] SRC_PIN0 = 4'h0;
   localparam logic [3:0] SRC_PIN1 = 4'h1;
   localparam logic [3:0] SRC_G0   = 4'h2;
   localparam logic [3:0] SRC_T0   = 4'h3;
   localparam logic [3:0] SRC_T1   = 4'h4;
   localparam logic [3:0] SRC_G1   = 4'h5;
   localparam logic [3:0] SRC_G2   = 4'h6;
   localparam logic [3:0] SRC_AD   = 4'h7;
   localparam logic [3:0] SRC_LV   = 4'h8;

   localparam logic [2:0] SRC_REG [NUM_SRC] = '{REG_CTRL_A, REG_CTRL_A, REG_CTRL_A,
                                               REG_CTRL_B, REG_CTRL_B, REG_CTRL_B,
                                               REG_CTRL_B, REG_CTRL_C, REG_CTRL_C};
   localparam logic [2:0] SRC_REQ_BIT [NUM_SRC] = '{CA_PIN0_REQ, CA_PIN1_REQ, CA_G0_REQ,
                                                   CB_T0_REQ, CB_T1_REQ, CB_G1_REQ,
                                                   CB_G2_REQ, CC_AD_REQ, CC_LV_REQ};
   localparam logic [2:0] SRC_EN_BIT [NUM_SRC] = '{CA_PIN0_EN, CA_PIN1_EN, CA_G0_EN,
                                                  CB_T0_EN, CB_T1_EN, CB_G1_EN,
                                                  CB_G2_EN, CC_AD_EN, CC_LV_EN};

endpackage : ifb_pkg

// file: core/ifb_pin_edge.sv
// Pin synchroniser and selectable edge detector
`timescale 1ns/100ps
module ifb_pin_edge
   import ifb_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       pinIn,
   input  wire logic [1:0] edgeSel,
   output logic            edgePulse
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } ifb_edge_state_t;

   ifb_edge_state_t st_reg;
   ifb_edge_state_t st_next;
   logic            rise;
   logic            fall;

   // ==========================================================
   // Two-stage synchroniser, then one more stage for history
   always_comb begin
      st_next      = st_reg;
      st_next.s1   = pinIn;
      st_next.s2   = st_reg.s1;
      st_next.prev = st_reg.s2;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign rise = st_reg.s2 & ~st_reg.prev;
   assign fall = ~st_reg.s2 & st_reg.prev;
   // Code off gives no pulse at all
   assign edgePulse = (rise && (edgeSel == EDGE_RISE || edgeSel == EDGE_BOTH)) ||
                      (fall && (edgeSel == EDGE_FALL || edgeSel == EDGE_BOTH));

   a_edge_off_quiet: assert property (@(posedge clk) disable iff (rst)
      (edgeSel == EDGE_OFF) |-> !edgePulse)
      else $error("edge pulse while edge field is off");
   a_rise_only_high: assert property (@(posedge clk) disable iff (rst)
      (edgePulse && edgeSel == EDGE_RISE) |-> (st_reg.s2 && !st_reg.prev))
      else $error("rising code fired without a rising edge");
   a_fall_only_low: assert property (@(posedge clk) disable iff (rst)
      (edgePulse && edgeSel == EDGE_FALL) |-> (!st_reg.s2 && st_reg.prev))
      else $error("falling code fired without a falling edge");

endmodule : ifb_pin_edge

// file: core/ifb_prio_pick.sv
// Fixed-priority picker, lowest index wins
`timescale 1ns/100ps
module ifb_prio_pick #(
   parameter int N = 9,
   parameter int W = 4
) (
   input  wire logic [N-1:0] req,
   output logic [W-1:0]      idx,
   output logic              any
);

   always_comb begin
      idx = '0;
      any = |req;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = W'(i);
         end
      end
   end

endmodule : ifb_prio_pick

// file: core/ifb_irq_bank.sv
// Interrupt flag and enable register bank with request dispatch
`timescale 1ns/100ps
module ifb_irq_bank
   import ifb_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [2:0]       regAddr,
   input  wire logic             regWr,
   input  wire logic [7:0]       regWrData,
   output logic      [7:0]       regRdData,
   input  wire logic             pin0In,
   input  wire logic             pin1In,
   input  wire logic             tick0Evt,
   input  wire logic             tick1Evt,
   input  wire logic             convDoneEvt,
   input  wire logic             lowvoltEvt,
   input  wire logic [3:0]       timerEvt,
   input  wire logic [3:0]       pwmLowEvt,
   input  wire logic [1:0]       pwmHighEvt,
   input  wire logic             stackFull,
   input  wire logic             irqAck,
   output logic                  irqReq,
   output logic      [SRC_W-1:0] irqVector
);

   typedef struct packed {
      logic [NUM_REGS-1:0][7:0] bank;
      logic [7:0]               rdData;
      logic                     irqReq;
      logic [SRC_W-1:0]         irqVec;
   } ifb_bank_state_t;

   ifb_bank_state_t          st_reg;
   ifb_bank_state_t          st_next;
   logic [NUM_REGS-1:0][7:0] hwSet;
   logic [NUM_REGS-1:0][7:0] hwClr;
   logic [NUM_SRC-1:0]       pending;
   logic [SRC_W-1:0]         pickIdx;
   logic                     pickAny;
   logic                     pin0Edge;
   logic                     pin1Edge;
   logic                     take;

   // ==========================================================
   // External pins
   ifb_pin_edge u_pin0 (
      .clk       (clk),
      .rst       (rst),
      .pinIn     (pin0In),
      .edgeSel   (st_reg.bank[REG_EDGE][EDGE_PIN0_LSB +: 2]),
      .edgePulse (pin0Edge)
   );

   ifb_pin_edge u_pin1 (
      .clk       (clk),
      .rst       (rst),
      .pinIn     (pin1In),
      .edgeSel   (st_reg.bank[REG_EDGE][EDGE_PIN1_LSB +: 2]),
      .edgePulse (pin1Edge)
   );

   // ==========================================================
   // Pending requests and priority
   generate
      for (genvar s = 0; s < NUM_SRC; s++) begin : g_pend
         assign pending[s] = st_reg.bank[SRC_REG[s]][SRC_REQ_BIT[s]] &
                             st_reg.bank[SRC_REG[s]][SRC_EN_BIT[s]];
      end
   endgenerate

   ifb_prio_pick #(
      .N (NUM_SRC),
      .W (SRC_W)
   ) u_pick (
      .req (pending),
      .idx (pickIdx),
      .any (pickAny)
   );

   // The core only takes what is currently offered
   assign take = irqAck && st_reg.irqReq;

   // ==========================================================
   // Next state
   always_comb begin
      st_next = st_reg;
      hwSet   = '0;
      hwClr   = '0;

      // Hardware events; flags set regardless of their enables
      hwSet[REG_CTRL_A][CA_PIN0_REQ] = pin0Edge;
      hwSet[REG_CTRL_A][CA_PIN1_REQ] = pin1Edge;
      hwSet[REG_CTRL_B][CB_T0_REQ]   = tick0Evt;
      hwSet[REG_CTRL_B][CB_T1_REQ]   = tick1Evt;
      hwSet[REG_CTRL_C][CC_AD_REQ]   = convDoneEvt;
      hwSet[REG_CTRL_C][CC_LV_REQ]   = lowvoltEvt;
      hwSet[REG_GRP_TMR][7:4]        = timerEvt;
      hwSet[REG_GRP_PWML][7:4]       = pwmLowEvt;
      hwSet[REG_GRP_PWMH][5:4]       = pwmHighEvt;

      // A source reaches its group only through its own enable
      hwSet[REG_CTRL_A][CA_G0_REQ] = |(timerEvt & st_reg.bank[REG_GRP_TMR][3:0]);
      hwSet[REG_CTRL_B][CB_G1_REQ] = |(pwmLowEvt & st_reg.bank[REG_GRP_PWML][3:0]);
      hwSet[REG_CTRL_B][CB_G2_REQ] = |(pwmHighEvt & st_reg.bank[REG_GRP_PWMH][1:0]);

      // Service clears global enable and the primary flag served only;
      // group source flags are left for software
      if (take) begin
         hwClr[REG_CTRL_A][CA_GIE] = 1'b1;
         for (int i = 0; i < NUM_SRC; i++) begin
            if (st_reg.irqVec == SRC_W'(i)) begin
               hwClr[SRC_REG[i]][SRC_REQ_BIT[i]] = 1'b1;
            end
         end
      end

      // Software write, then hardware clear, then hardware set:
      // an event in the clear cycle survives
      for (int r = 0; r < NUM_REGS; r++) begin
         if (regWr && regAddr == 3'(r)) begin
            st_next.bank[r] = regWrData;
         end
         st_next.bank[r] = ((st_next.bank[r] & ~hwClr[r]) | hwSet[r]) &
                           IMPL_MASK[r];
      end

      // Unimplemented bits and the unused select code read zero
      if (regAddr < 3'(NUM_REGS)) begin
         st_next.rdData = st_reg.bank[regAddr] & IMPL_MASK[regAddr];
      end else begin
         st_next.rdData = 8'h00;
      end

      // Offer a request only with global enable and stack room
      st_next.irqReq = st_reg.bank[REG_CTRL_A][CA_GIE] && pickAny &&
                       !stackFull && !take;
      if (pickAny) begin
         st_next.irqVec = pickIdx;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign regRdData = st_reg.rdData;
   assign irqReq    = st_reg.irqReq;
   assign irqVector = st_reg.irqVec;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   a_edge_high_zero: assert property (
      (regAddr == REG_EDGE) |=> (regRdData[7:4] == 4'h0))
      else $error("edge register upper bits not zero");

   a_ctrla_bit7_zero: assert property (
      (regAddr == REG_CTRL_A) |=> !regRdData[7])
      else $error("control A bit 7 not zero");

   a_ctrlc_gaps_zero: assert property (
      (regAddr == REG_CTRL_C) |=> (regRdData[7:6] == 2'h0 && regRdData[3:2] == 2'h0))
      else $error("control C unimplemented bits not zero");

   a_pwmh_gaps_zero: assert property (
      (regAddr == REG_GRP_PWMH) |=> (regRdData[7:6] == 2'h0 && regRdData[3:2] == 2'h0))
      else $error("PWM high unimplemented bits not zero");

   a_edge_write_read: assert property (
      (regWr && regAddr == REG_EDGE) ##1 (regAddr == REG_EDGE && !regWr)
      |=> (regRdData == {4'h0, $past(regWrData[3:0], 2)}))
      else $error("edge register write not read back");

   a_flag_while_off: assert property (
      (convDoneEvt && !st_reg.bank[REG_CTRL_C][CC_AD_EN])
      |=> st_reg.bank[REG_CTRL_C][CC_AD_REQ])
      else $error("disabled conversion event lost");

   a_gie_self_clear: assert property (
      (irqAck && irqReq) |=> !st_reg.bank[REG_CTRL_A][CA_GIE] ##1 !irqReq)
      else $error("global enable survived a taken interrupt");

   a_source_kept: assert property (
      (irqAck && irqReq && irqVector == SRC_G0 && !regWr)
      |=> ((st_reg.bank[REG_GRP_TMR][7:4] & $past(st_reg.bank[REG_GRP_TMR][7:4]))
           == $past(st_reg.bank[REG_GRP_TMR][7:4])))
      else $error("timer source flag cleared by service");

   a_group_set: assert property (
      (|(pwmLowEvt & st_reg.bank[REG_GRP_PWML][3:0])) |=> st_reg.bank[REG_CTRL_B][CB_G1_REQ])
      else $error("group 1 flag not set by enabled source");

   a_stack_block: assert property (
      stackFull |=> !irqReq)
      else $error("request offered while stack full");

   a_req_needs_gie: assert property (
      irqReq |-> $past(st_reg.bank[REG_CTRL_A][CA_GIE]) && $past(pickAny))
      else $error("request without global enable");

   a_served_cleared: assert property (
      (irqAck && irqReq && irqVector == SRC_G2 && !pwmHighEvt[0] && !pwmHighEvt[1])
      |=> !st_reg.bank[REG_CTRL_B][CB_G2_REQ])
      else $error("group 2 flag not cleared on service");

endmodule : ifb_irq_bank

// file: tb/ifb_core_model.sv
// Core-side model that takes the interrupt requests offered by the bank
`timescale 1ns/100ps
module ifb_core_model
   import ifb_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             irqReq,
   input  wire logic [SRC_W-1:0] irqVector,
   input  wire logic             ackOn,
   input  wire logic [3:0]       ackWait,
   output logic                  irqAck,
   output logic      [SRC_W-1:0] lastVec,
   output int                    takes
);
   int waited;

   initial begin
      irqAck = 1'b0;
      lastVec = '0;
      takes = 0;
      waited = 0;
   end

   // ==========================================================
   // Take logic
   // A one-cycle pulse only, so a request is never taken twice
   always @(posedge clk) begin
      #1;
      if (rst || !irqReq || irqAck || !ackOn) begin
         irqAck = 1'b0;
         waited = 0;
      end else if (waited < int'(ackWait)) begin
         waited++;
      end else begin
         irqAck = 1'b1;
         lastVec = irqVector;
         takes++;
      end
   end
endmodule : ifb_core_model

// file: tb/ifb_irq_bank_test.sv
// Self-checking bench for the interrupt flag and enable bank
`timescale 1ns/100ps
module ifb_irq_bank_test
   import ifb_pkg::*;
;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic       [2:0] regAddr = '0;
   logic             regWr = 1'b0;
   logic       [7:0] regWrData = '0;
   logic       [1:0] pins = '0;
   logic       [3:0] primEvt = '0;
   logic       [3:0] timerEvt = '0;
   logic       [3:0] pwmLowEvt = '0;
   logic       [1:0] pwmHighEvt = '0;
   logic             stackFull = 1'b0;
   logic             ackOn = 1'b0;
   logic       [3:0] ackWait = '0;
   logic       [7:0] regRdData;
   logic             irqReq;
   logic             irqAck;
   logic [SRC_W-1:0] irqVector;
   logic [SRC_W-1:0] lastVec;
   int               takes;
   int               badCount = 0;
   int               checksDone = 0;
   int               cycles = 0;

   ifb_irq_bank dut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWr(regWr),
      .regWrData(regWrData), .regRdData(regRdData), .pin0In(pins[0]), .pin1In(pins[1]),
      .tick0Evt(primEvt[0]), .tick1Evt(primEvt[1]), .convDoneEvt(primEvt[2]),
      .lowvoltEvt(primEvt[3]), .timerEvt(timerEvt), .pwmLowEvt(pwmLowEvt),
      .pwmHighEvt(pwmHighEvt), .stackFull(stackFull), .irqAck(irqAck),
      .irqReq(irqReq), .irqVector(irqVector));

   ifb_core_model core (.clk(clk), .rst(rst), .irqReq(irqReq), .irqVector(irqVector),
      .ackOn(ackOn), .ackWait(ackWait), .irqAck(irqAck), .lastVec(lastVec), .takes(takes));

   always #25 clk = ~clk;

   // ==========================================================
   // Compare and access tasks
   task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checksDone++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : checkByte

   task automatic checkVec(input string what, input logic [3:0] exp, input logic [3:0] got);
      checksDone++;
      if (got !== exp) begin
         badCount++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : checkVec

   task automatic idle(input int n);
      regWr = 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask : idle

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      regAddr = a;
      regWr = 1'b1;
      regWrData = d;
      @(posedge clk);
      // Strobe stays up; the next task lowers it, so back-to-back writes never toggle it
      #1;
   endtask : wr

   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      regAddr = a;
      regWr = 1'b0;
      @(posedge clk);
      #1 checkByte($sformatf("register %0d", a), exp, regRdData);
   endtask : rd

   task automatic evt(input logic [3:0] pe, input logic [3:0] te, input logic [3:0] le,
                      input logic [1:0] he);
      regWr = 1'b0;
      primEvt = pe;
      timerEvt = te;
      pwmLowEvt = le;
      pwmHighEvt = he;
      @(posedge clk);
      #1 {primEvt, timerEvt, pwmLowEvt, pwmHighEvt} = '0;
   endtask : evt

   task automatic waitTake(input int n);
      for (int k = 0; k < 50 && takes < n; k++) idle(1);
      // One more edge so the take itself has landed in the bank
      idle(1);
      checkByte("takes", 8'(n), 8'(takes));
   endtask : waitTake

   task automatic tallyAndFinish();
      $display("checks %0d mismatches %0d", checksDone, badCount);
      if (badCount == 0 && checksDone > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tallyAndFinish

   // ==========================================================
   // Hang guard, roughly fifteen times the expected run
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         badCount++;
         tallyAndFinish();
      end
   end

   // ==========================================================
   // Test sequence
   initial begin
      idle(3);
      rst = 1'b0;
      for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
      $display("test reset values done");
      // Unmapped select 7 must read back zero after a write
      for (int i = 0; i < 8; i++) begin
         wr(3'(i), 8'hFF);
         rd(3'(i), (i < NUM_REGS) ? IMPL_MASK[i] : 8'h00);
         wr(3'(i), 8'h00);
      end
      $display("test register masks done");
      for (int c = 0; c < 4; c++) begin
         for (int p = 0; p < 2; p++) begin
            wr(REG_EDGE, 8'(c << (2 * p)));
            wr(REG_CTRL_A, 8'h00);
            pins[p] = 1'b1;
            idle(4);
            rd(REG_CTRL_A, c[0] ? 8'(8'h10 << p) : 8'h00);
            wr(REG_CTRL_A, 8'h00);
            pins[p] = 1'b0;
            idle(4);
            rd(REG_CTRL_A, c[1] ? 8'(8'h10 << p) : 8'h00);
         end
      end
      $display("test edge codes done");
      wr(REG_CTRL_A, 8'h01);
      evt(4'hF, 4'h0, 4'h0, 2'h0);
      idle(2);
      checkByte("request", 8'h00, {7'h00, irqReq});
      rd(REG_CTRL_B, 8'h30);
      rd(REG_CTRL_C, 8'h30);
      wr(REG_CTRL_A, 8'h00);
      wr(REG_CTRL_B, 8'h00);
      wr(REG_CTRL_C, 8'h00);
      $display("test disabled flags done");
      wr(REG_GRP_TMR, 8'h0F);
      evt(4'h0, 4'hF, 4'h0, 2'h0);
      rd(REG_GRP_TMR, 8'hFF);
      rd(REG_CTRL_A, 8'h40);
      evt(4'h0, 4'h0, 4'hF, 2'h0);
      rd(REG_GRP_PWML, 8'hF0);
      rd(REG_CTRL_B, 8'h00);
      wr(REG_GRP_PWMH, 8'h03);
      evt(4'h0, 4'h0, 4'h0, 2'h3);
      rd(REG_GRP_PWMH, 8'h33);
      rd(REG_CTRL_B, 8'h80);
      $display("test groups done");
      ackOn = 1'b1;
      wr(REG_CTRL_A, 8'h48);
      idle(3);
      checkByte("request", 8'h00, {7'h00, irqReq});
      stackFull = 1'b1;
      wr(REG_CTRL_A, 8'h49);
      idle(3);
      checkByte("request", 8'h00, {7'h00, irqReq});
      stackFull = 1'b0;
      waitTake(1);
      checkVec("vector", SRC_G0, lastVec);
      rd(REG_CTRL_A, 8'h08);
      rd(REG_GRP_TMR, 8'hFF);
      wr(REG_GRP_TMR, 8'h00);
      rd(REG_GRP_TMR, 8'h00);
      ackWait = 4'h3;
      wr(REG_CTRL_B, 8'h01);
      wr(REG_CTRL_A, 8'h01);
      evt(4'h1, 4'h0, 4'h0, 2'h0);
      waitTake(2);
      checkVec("vector", SRC_T0, lastVec);
      rd(REG_CTRL_B, 8'h01);
      rd(REG_CTRL_A, 8'h00);
      ackWait = 4'h0;
      wr(REG_CTRL_B, 8'h08);
      evt(4'h0, 4'h0, 4'h0, 2'h1);
      wr(REG_CTRL_A, 8'h01);
      waitTake(3);
      checkVec("vector", SRC_G2, lastVec);
      rd(REG_CTRL_B, 8'h08);
      rd(REG_GRP_PWMH, 8'h33);
      $display("test dispatch done");
      tallyAndFinish();
   end
endmodule : ifb_irq_bank_test
